// File: pm_event_pkg.sv
// package: register map, field positions, timing and bus carriers for the pm event block
package pm_event_pkg;

  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_SHORT_MS = 4;
  localparam int TICK_SHORT_CYCLES = (CLK_HZ / 1000) * TICK_SHORT_MS;
  localparam int TICK_LONG_MS = 8;
  localparam int TICK_LONG_PER_SHORT = TICK_LONG_MS / TICK_SHORT_MS;
  localparam logic [1:0] HIGH_SAMPLES_LAST = 2'h2;
  localparam logic [2:0] LOW_SAMPLES_LAST = 3'h3;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_UNIT_CTRL = 8'h40;
  localparam logic [7:0] IDX_SUSPEND_CTRL = 8'h50;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h5C;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h5D;
  localparam logic [7:0] IDX_PIN_MODE = 8'h61;
  localparam logic [7:0] IDX_EXT_CTRL = 8'hA1;

  // field positions
  localparam int POL_EXT_ONE_BIT = 1;
  localparam int POL_EXT_TWO_BIT = 2;
  localparam int SUSPEND_BIT = 0;
  localparam int EV_EXT_ONE_BIT = 1;
  localparam int EV_EXT_TWO_BIT = 2;
  localparam int EV_SEVEN_BIT = 7;
  localparam int PIN_MODE_LO = 4;
  localparam int OVERTEMP_EN_BIT = 2;
  localparam int LATCH_EN_BIT = 0;

  // reset values
  localparam logic [7:0] UNIT_CTRL_RST = 8'h00;
  localparam logic [7:0] EVENT_MASK_RST = 8'h86;
  localparam logic [1:0] PIN_MODE_RST = 2'h0;
  localparam logic [7:0] EVENT_STATUS_MASK = 8'h86;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PIN_EDGE,
    PIN_LEVEL,
    PIN_SAMPLE_SHORT,
    PIN_SAMPLE_LONG
  } pin_mode_e;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_s;

  // word-aligned byte address to register index
  function automatic logic [7:0] addr_to_idx(input logic [31:0] addr);
    return addr[9:2];
  endfunction

  function automatic logic addr_mapped(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    return (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) &&
      (idx == IDX_UNIT_CTRL || idx == IDX_SUSPEND_CTRL || idx == IDX_EVENT_STATUS ||
       idx == IDX_EVENT_MASK || idx == IDX_PIN_MODE || idx == IDX_EXT_CTRL);
  endfunction

endpackage

// File: level_sampler.sv
// level sampler: fires once after three high samples, re-arms after four low samples
module level_sampler
  import pm_event_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // sampling
  input wire logic enable,
  input wire logic tick,
  input wire logic level,
  // result
  output logic fire
);

  logic [1:0] high_cnt;
  logic [2:0] low_cnt;
  logic armed;

  // disabled sampler restarts armed so a mode switch never leaves it stuck
  always_ff @(posedge clk_sys) begin
    if (srst || !enable) begin
      high_cnt <= 2'h0;
      low_cnt <= 3'h0;
      armed <= 1'b1;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (tick) begin
        if (level) begin
          low_cnt <= 3'h0;
          if (armed) begin
            if (high_cnt == HIGH_SAMPLES_LAST) begin
              fire <= 1'b1;
              armed <= 1'b0;
              high_cnt <= 2'h0;
            end else begin
              high_cnt <= high_cnt + 2'h1;
            end
          end
        end else begin
          high_cnt <= 2'h0;
          if (!armed) begin
            if (low_cnt == LOW_SAMPLES_LAST) begin
              armed <= 1'b1;
              low_cnt <= 3'h0;
            end else begin
              low_cnt <= low_cnt + 3'h1;
            end
          end
        end
      end
    end
  end

endmodule // level_sampler

// File: pm_event_unit.sv
// power-management event unit: suspend/resume pin, external inputs, interrupt, axi4-lite regs
// Operation
// - mode 11 raises interrupt 16 to 24ms after high
// - suspended, mode 00 falling edge resumes, sets seven
// - writing 50h bit 0 enters suspend
// - writing 5Ch bit 7 clears event seven
// - A1h bit 2 lets input two force cool-down
// - forcing works without thermal feature enabled
// - input two polarity from 40h bit 2
// - overtemp enable sticks until hardware reset
// - A1h bit 0 latches input one, two events
// - latched status holds, write one clears
// - latch disabled keeps live legacy status
// - mode 00 falling edge sets sticky seven
// - mode 01 event seven follows low pin
// - mode 10 three highs fire, four lows re-arm
// - mode 11 same with 8ms tick
module pm_event_unit
  import pm_event_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_SHORT_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register bus
  input wire axi_req_s axi_req,
  output axi_rsp_s axi_rsp,
  // pins
  input wire logic suspend_resume_pin,
  input wire logic ext_pm_input_one,
  input wire logic ext_pm_input_two,
  // system side
  output logic system_mgmt_interrupt_n,
  output logic suspended,
  output logic cool_down_force
);

  // registers
  logic [7:0] unit_ctrl;
  logic [7:0] event_mask;
  logic [1:0] pin_mode;
  logic overtemp_en;
  logic latch_en;
  logic ev_seven_sticky;
  logic [2:1] ext_sticky;

  // bus state
  logic aw_got;
  logic w_got;
  logic [31:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;

  // tick generation
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
  logic tick_short;
  logic tick_phase;
  logic tick_long;
  logic sample_tick;

  // pin logic
  logic pin_prev;
  logic pin_fall;
  logic sampler_fire;
  logic pin_event;
  logic ext_one_act;
  logic ext_two_act;

  // derived
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] status_view;
  logic [7:0] next_rdata;
  pin_mode_e mode;

  assign mode = pin_mode_e'(pin_mode);
  assign wr_en = aw_got && w_got && !axi_rsp.bvalid && w_lane && addr_mapped(aw_addr);
  assign wr_idx = addr_to_idx(aw_addr);
  assign wr_data = w_byte;

  // ---------------- axi4-lite slave ----------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      axi_rsp.awready <= 1'b0;
      axi_rsp.wready <= 1'b0;
      axi_rsp.bvalid <= 1'b0;
      axi_rsp.bresp <= RESP_OKAY;
    end else begin
      axi_rsp.awready <= !aw_got && !(axi_req.awvalid && axi_rsp.awready);
      axi_rsp.wready <= !w_got && !(axi_req.wvalid && axi_rsp.wready);
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_got <= 1'b1;
        aw_addr <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_got <= 1'b1;
        w_byte <= axi_req.wdata[7:0];
        w_lane <= axi_req.wstrb[0];
      end
      if (aw_got && w_got && !axi_rsp.bvalid) begin
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_rsp.bvalid && axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        axi_rsp.awready <= 1'b1;
        axi_rsp.wready <= 1'b1;
      end
    end
  end

  // read data mux; narrow registers sit in the low byte
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr_to_idx(axi_req.araddr))
      IDX_UNIT_CTRL: next_rdata = unit_ctrl;
      IDX_SUSPEND_CTRL: next_rdata = {7'h00, suspended};
      IDX_EVENT_STATUS: next_rdata = status_view;
      IDX_EVENT_MASK: next_rdata = event_mask;
      IDX_PIN_MODE: next_rdata = {2'h0, pin_mode, 4'h0};
      IDX_EXT_CTRL: next_rdata = {5'h00, overtemp_en, 1'b0, latch_en};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid <= 1'b0;
      axi_rsp.rdata <= 32'h0000_0000;
      axi_rsp.rresp <= RESP_OKAY;
    end else begin
      axi_rsp.arready <= !axi_rsp.rvalid && !(axi_req.arvalid && axi_rsp.arready);
      if (axi_req.arvalid && axi_rsp.arready) begin
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rdata <= addr_mapped(axi_req.araddr) ? {24'h000000, next_rdata} : 32'h0000_0000;
        axi_rsp.rresp <= addr_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_rsp.rvalid && axi_req.rready) begin
        axi_rsp.rvalid <= 1'b0;
        axi_rsp.arready <= 1'b1;
      end
    end
  end

  // ---------------- plain control registers ----------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      unit_ctrl <= UNIT_CTRL_RST;
      event_mask <= EVENT_MASK_RST;
      pin_mode <= PIN_MODE_RST;
      latch_en <= 1'b0;
    end else if (wr_en) begin
      if (wr_idx == IDX_UNIT_CTRL) begin
        unit_ctrl <= wr_data;
      end
      if (wr_idx == IDX_EVENT_MASK) begin
        event_mask <= wr_data & EVENT_STATUS_MASK;
      end
      if (wr_idx == IDX_PIN_MODE) begin
        pin_mode <= wr_data[PIN_MODE_LO +: 2];
      end
      if (wr_idx == IDX_EXT_CTRL) begin
        latch_en <= wr_data[LATCH_EN_BIT];
      end
    end
  end

  // only srst clears the emergency enable; zero writes are ignored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      overtemp_en <= 1'b0;
    end else if (wr_en && wr_idx == IDX_EXT_CTRL && wr_data[OVERTEMP_EN_BIT]) begin
      overtemp_en <= 1'b1;
    end
  end

  // ---------------- sampling ticks ----------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_cnt <= '0;
      tick_short <= 1'b0;
      tick_phase <= 1'b0;
    end else begin
      tick_short <= 1'b0;
      if (tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
        tick_short <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
      if (tick_short) begin
        tick_phase <= !tick_phase;
      end
    end
  end

  // long tick is every second short tick
  assign tick_long = tick_short && tick_phase == 1'(TICK_LONG_PER_SHORT - 1);
  assign sample_tick = (mode == PIN_SAMPLE_LONG) ? tick_long : tick_short;

  level_sampler sampler (
    .clk_sys(clk_sys),
    .srst(srst),
    .enable(mode == PIN_SAMPLE_SHORT || mode == PIN_SAMPLE_LONG),
    .tick(sample_tick),
    .level(suspend_resume_pin),
    .fire(sampler_fire)
  );

  // ---------------- suspend/resume pin ----------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= suspend_resume_pin;
    end
  end

  assign pin_fall = pin_prev && !suspend_resume_pin;

  always_comb begin
    pin_event = 1'b0;
    unique case (mode)
      PIN_EDGE: pin_event = pin_fall;
      PIN_LEVEL: pin_event = !suspend_resume_pin;
      PIN_SAMPLE_SHORT: pin_event = sampler_fire;
      PIN_SAMPLE_LONG: pin_event = sampler_fire;
    endcase
  end

  // set wins over a same-cycle clear; level mode keeps no latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ev_seven_sticky <= 1'b0;
    end else if (mode == PIN_LEVEL) begin
      ev_seven_sticky <= 1'b0;
    end else if (pin_event) begin
      ev_seven_sticky <= 1'b1;
    end else if (wr_en && wr_idx == IDX_EVENT_STATUS && wr_data[EV_SEVEN_BIT]) begin
      ev_seven_sticky <= 1'b0;
    end
  end

  // resume on the pin's event while suspended; software's write enters suspend
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      suspended <= 1'b0;
    end else if (suspended && pin_event) begin
      suspended <= 1'b0;
    end else if (wr_en && wr_idx == IDX_SUSPEND_CTRL && wr_data[SUSPEND_BIT]) begin
      suspended <= 1'b1;
    end
  end

  // ---------------- external inputs ----------------
  assign ext_one_act = ext_pm_input_one ^ unit_ctrl[POL_EXT_ONE_BIT];
  assign ext_two_act = ext_pm_input_two ^ unit_ctrl[POL_EXT_TWO_BIT];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_sticky <= 2'h0;
    end else if (!latch_en) begin
      ext_sticky <= 2'h0;
    end else begin
      for (int i = EV_EXT_ONE_BIT; i <= EV_EXT_TWO_BIT; i++) begin
        if (i == EV_EXT_ONE_BIT ? ext_one_act : ext_two_act) begin
          ext_sticky[i] <= 1'b1;
        end else if (wr_en && wr_idx == IDX_EVENT_STATUS && wr_data[i]) begin
          ext_sticky[i] <= 1'b0;
        end
      end
    end
  end

  // status word: event seven live in level mode, inputs live when unlatched
  always_comb begin
    status_view = 8'h00;
    status_view[EV_SEVEN_BIT] = (mode == PIN_LEVEL) ? !suspend_resume_pin : ev_seven_sticky;
    status_view[EV_EXT_ONE_BIT] = latch_en ? ext_sticky[EV_EXT_ONE_BIT] : ext_one_act;
    status_view[EV_EXT_TWO_BIT] = latch_en ? ext_sticky[EV_EXT_TWO_BIT] : ext_two_act;
  end

  // ---------------- outputs ----------------
  // forcing ignores any thermal feature enable; only the emergency bit gates it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cool_down_force <= 1'b0;
      system_mgmt_interrupt_n <= 1'b1;
    end else begin
      cool_down_force <= overtemp_en && ext_two_act;
      system_mgmt_interrupt_n <= !(|(status_view & event_mask));
    end
  end

endmodule // pm_event_unit

// File: pm_pin_source.sv
// pin source model: lid switch and the two sense inputs
module pm_pin_source
(
  // clock
  input wire logic clk_sys,
  // wanted levels
  input wire logic lid_closed,
  input wire logic sense_one,
  input wire logic sense_two,
  // pins
  output logic suspend_resume_pin,
  output logic ext_pm_input_one,
  output logic ext_pm_input_two
);
  timeunit 1ns / 1ps;
  // contacts settle on a clock edge, so pins never move inside a sampling step
  always_ff @(posedge clk_sys) begin
    suspend_resume_pin <= lid_closed;
    ext_pm_input_one <= sense_one;
    ext_pm_input_two <= sense_two;
  end
endmodule // pm_pin_source

// File: pm_event_checker.sv
// checker: bus timing, suspend entry and overtemp forcing at the unit ports
module pm_event_checker
  import pm_event_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // bus and pins
  input wire axi_req_s axi_req,
  input wire axi_rsp_s axi_rsp,
  input wire logic suspend_resume_pin,
  input wire logic ext_pm_input_one,
  input wire logic ext_pm_input_two,
  // system side
  input wire logic system_mgmt_interrupt_n,
  input wire logic suspended,
  input wire logic cool_down_force
);
  timeunit 1ns / 1ps;
  logic wr, ot_en, pol2;
  assign wr = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  // shadow of the enable: a zero write is dropped, as the sticky bit must
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ot_en <= 1'b0;
      pol2 <= 1'b0;
    end else if (wr && axi_req.wstrb[0] && axi_req.awaddr == 32'h284) begin
      ot_en <= ot_en | axi_req.wdata[2];
    end else if (wr && axi_req.wstrb[0] && axi_req.awaddr == 32'h100) begin
      pol2 <= axi_req.wdata[2];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  property p_b_hold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  property p_r_hold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  property p_b_lat;
    s_wr_take |-> ##2 axi_rsp.bvalid;
  endproperty
  property p_r_lat;
    s_rd_take |=> axi_rsp.rvalid;
  endproperty
  property p_r_top;
    axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0;
  endproperty
  property p_susp;
    s_wr_take ##0 (axi_req.awaddr == 32'h140 && axi_req.wdata[0] && axi_req.wstrb[0])
      |-> ##[1:2] suspended;
  endproperty
  property p_cool_off;
    !ot_en |-> !cool_down_force;
  endproperty
  // five cycles of slack cover the enable's write latency and the output flop
  property p_cool_on;
    (ot_en && (ext_pm_input_two ^ pol2))[*5] |-> cool_down_force;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response changed before taken");
  a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  a_r_lat: assert property (p_r_lat) else $error("read response late");
  a_r_top: assert property (p_r_top) else $error("read data upper bits set");
  a_susp: assert property (p_susp) else $error("suspend not entered");
  a_cool_off: assert property (p_cool_off) else $error("forcing without enable");
  a_cool_on: assert property (p_cool_on) else $error("forcing missing");
endmodule // pm_event_checker

bind pm_event_unit pm_event_checker chk (.clk_sys, .srst, .axi_req, .axi_rsp,
  .suspend_resume_pin, .ext_pm_input_one, .ext_pm_input_two, .system_mgmt_interrupt_n,
  .suspended, .cool_down_force);

// File: pm_event_unit_tb.sv
// testbench: bus, pin modes, suspend, external inputs and overtemp of the pm unit
module pm_event_unit_tb
  import pm_event_pkg::*;
;
  timeunit 1ns / 1ps;
  localparam int TK = 8;
  logic clk_sys, srst, lid, s1, s2, pin, e1, e2, irq_n, susp, cool;
  axi_req_s req;
  axi_rsp_s rsp;
  logic [31:0] d;
  logic [1:0] rr, br;
  logic [7:0] p;
  int err_total = 0;
  int tests_run = 0;
  int t, n;
  int adr[$] = '{32'h100, 32'h140, 32'h170, 32'h174, 32'h184, 32'h284};
  pm_pin_source src (.clk_sys(clk_sys), .lid_closed(lid), .sense_one(s1), .sense_two(s2),
    .suspend_resume_pin(pin), .ext_pm_input_one(e1), .ext_pm_input_two(e2));
  pm_event_unit #(.TICK_CYCLES(TK)) uut (.clk_sys(clk_sys), .srst(srst), .axi_req(req),
    .axi_rsp(rsp), .suspend_resume_pin(pin), .ext_pm_input_one(e1), .ext_pm_input_two(e2),
    .system_mgmt_interrupt_n(irq_n), .suspended(susp), .cool_down_force(cool));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic end_sim();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // both channels offered together, each released at its own ready
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic ta, tw;
    int k;
    k = $urandom_range(3, 0);
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= {24'h0, v};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(posedge clk_sys);
      if (!ta && rsp.awready === 1'b1) begin
        ta = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!tw && rsp.wready === 1'b1) begin
        tw = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    // a late bready keeps the response waiting, so its hold gets exercised
    repeat (k) @(posedge clk_sys);
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    int k;
    k = $urandom_range(3, 0);
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    repeat (k) @(posedge clk_sys);
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    chk(d, e);
  endtask
  // a = 1 drives both sense pins to their active level under polarity p
  task automatic ext(input logic a);
    s1 <= p[1] ^ a;
    s2 <= p[2] ^ a;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  initial begin
    req = '{wstrb: 4'hF, default: '0};
    srst = 1'b1;
    lid = 1'b0;
    s1 = 1'b0;
    s2 = 1'b0;
    p = 8'h00;
    void'($urandom(32'hDCB945A0));
    cyc(12);
    srst <= 1'b0;
    foreach (adr[i]) rdchk(adr[i], adr[i] == 32'h174 ? 32'h86 : 32'h0);
    rdchk(32'h4, 32'h0);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(32'h4, 8'hFF);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    lid <= 1'b1;
    cyc(4);
    lid <= 1'b0;
    cyc(6);
    rdchk(32'h170, 32'h80);
    cb(irq_n, 1'b0);
    wr(32'h174, 8'h00);
    cyc(3);
    cb(irq_n, 1'b1);
    wr(32'h174, 8'h86);
    cyc(3);
    cb(irq_n, 1'b0);
    wr(32'h170, 8'h80);
    cyc(3);
    cb(irq_n, 1'b1);
    rdchk(32'h170, 32'h0);
    wr(32'h184, 8'h10);
    cyc(3);
    cb(irq_n, 1'b0);
    lid <= 1'b1;
    cyc(4);
    cb(irq_n, 1'b1);
    rdchk(32'h170, 32'h0);
    for (int m = 2; m < 4; m++) begin
      t = (m - 1) * TK;
      wr(32'h184, 8'(m << 4));
      lid <= 1'b0;
      cyc(5 * t);
      wr(32'h170, 8'h80);
      lid <= 1'b1;
      n = 0;
      while (irq_n !== 1'b0 && n < 5 * t) begin
        @(posedge clk_sys);
        n++;
      end
      cb(n >= 2 * t && n <= 3 * t + 8, 1'b1);
      wr(32'h170, 8'h80);
      lid <= 1'b0;
      cyc(2 * t);
      lid <= 1'b1;
      cyc(4 * t);
      cb(irq_n, 1'b1);
      lid <= 1'b0;
      cyc(5 * t);
      lid <= 1'b1;
      cyc(3 * t + 8);
      cb(irq_n, 1'b0);
      wr(32'h170, 8'h80);
      lid <= 1'b0;
    end
    wr(32'h184, 8'h00);
    lid <= 1'b1;
    cyc(3);
    wr(32'h140, 8'h01);
    cyc(2);
    cb(susp, 1'b1);
    lid <= 1'b0;
    cyc(6);
    cb(susp, 1'b0);
    rdchk(32'h170, 32'h80);
    wr(32'h184, 8'h30);
    wr(32'h170, 8'h80);
    cyc(3);
    cb(irq_n, 1'b1);
    p = 8'($urandom) & 8'h06;
    wr(32'h100, p);
    ext(1'b1);
    cyc(4);
    rdchk(32'h170, 32'h6);
    cb(irq_n, 1'b0);
    ext(1'b0);
    cyc(4);
    rdchk(32'h170, 32'h0);
    wr(32'h284, 8'h01);
    ext(1'b1);
    cyc(3);
    ext(1'b0);
    cyc(3);
    rdchk(32'h170, 32'h6);
    wr(32'h170, 8'h06);
    rdchk(32'h170, 32'h0);
    wr(32'h284, 8'h05);
    ext(1'b1);
    cyc(6);
    cb(cool, 1'b1);
    ext(1'b0);
    cyc(6);
    cb(cool, 1'b0);
    wr(32'h284, 8'h00);
    rdchk(32'h284, 32'h4);
    ext(1'b1);
    cyc(6);
    cb(cool, 1'b1);
    srst <= 1'b1;
    s1 <= 1'b0;
    s2 <= 1'b0;
    cyc(2);
    srst <= 1'b0;
    foreach (adr[i]) rdchk(adr[i], adr[i] == 32'h174 ? 32'h86 : 32'h0);
    cb(cool, 1'b0);
    end_sim();
  end
endmodule // pm_event_unit_tb
